// file: prsd_pkg.sv
package prsd_pkg;
  localparam int PLAT_CODE_W = 4;
  localparam int CORE_CODE_W = 3;
  localparam int PLAT_MULT_W = 5;
  localparam int CORE_HALF_W = 4;
  // captured values after reset, before sampling
  localparam logic [PLAT_CODE_W-1:0] PLAT_CODE_RST = 4'h0;
  localparam logic [CORE_CODE_W-1:0] CORE_CODE_RST = 3'h0;
  localparam logic [PLAT_MULT_W-1:0] PLAT_MULT_RST = 5'h00;
  localparam logic [CORE_HALF_W-1:0] CORE_HALF_RST = 4'h0;
  // cycles after reset release before straps are sampled (synchroniser settles)
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // platform multipliers
  localparam logic [PLAT_MULT_W-1:0] PMUL_2  = 5'h02;
  localparam logic [PLAT_MULT_W-1:0] PMUL_3  = 5'h03;
  localparam logic [PLAT_MULT_W-1:0] PMUL_4  = 5'h04;
  localparam logic [PLAT_MULT_W-1:0] PMUL_5  = 5'h05;
  localparam logic [PLAT_MULT_W-1:0] PMUL_6  = 5'h06;
  localparam logic [PLAT_MULT_W-1:0] PMUL_8  = 5'h08;
  localparam logic [PLAT_MULT_W-1:0] PMUL_9  = 5'h09;
  localparam logic [PLAT_MULT_W-1:0] PMUL_10 = 5'h0a;
  localparam logic [PLAT_MULT_W-1:0] PMUL_12 = 5'h0c;
  localparam logic [PLAT_MULT_W-1:0] PMUL_16 = 5'h10;
  localparam logic [PLAT_MULT_W-1:0] PMUL_20 = 5'h14;
  // core ratio in halves: 4:1 -> 8, 9:2 -> 9
  localparam logic [CORE_HALF_W-1:0] CHALF_3 = 4'h3;
  localparam logic [CORE_HALF_W-1:0] CHALF_4 = 4'h4;
  localparam logic [CORE_HALF_W-1:0] CHALF_5 = 4'h5;
  localparam logic [CORE_HALF_W-1:0] CHALF_6 = 4'h6;
  localparam logic [CORE_HALF_W-1:0] CHALF_7 = 4'h7;
  localparam logic [CORE_HALF_W-1:0] CHALF_8 = 4'h8;
  localparam logic [CORE_HALF_W-1:0] CHALF_9 = 4'h9;
  typedef enum logic [2:0] {
    PRSD_SETTLE = 3'b001,
    PRSD_SAMPLE = 3'b010,
    PRSD_RUN    = 3'b100
  } prsd_state_t;
endpackage

// file: prsd_pll_ratio_strap_decoder.sv
`timescale 1ns/1ps
module prsd_pll_ratio_strap_decoder
  import prsd_pkg::*;
(
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  // board straps
  input  wire logic [prsd_pkg::PLAT_CODE_W-1:0]   platform_ratio_strap,
  input  wire logic                               core_ratio_strap_msb,
  input  wire logic                               core_ratio_strap_mid,
  input  wire logic                               core_ratio_strap_lsb,
  // platform clock feedback, for the memory bus divider
  input  wire logic                               platform_bus_clock,
  // decoded configuration
  output logic [prsd_pkg::PLAT_CODE_W-1:0]        plat_code,
  output logic [prsd_pkg::CORE_CODE_W-1:0]        core_code,
  output logic [prsd_pkg::PLAT_MULT_W-1:0]        plat_mult,
  output logic [prsd_pkg::CORE_HALF_W-1:0]        core_ratio_halves,
  output logic                                    cfg_valid,
  output logic                                    cfg_invalid,
  output logic                                    plat_pll_enable,
  output logic                                    core_pll_enable,
  output logic                                    mem_bus_clock
);
  import prsd_pkg::*;

  // second-stage outputs of the pin synchronisers; bit 7 is the feedback clock
  logic [7:0] sync2_ff;
  logic [7:0] pin_raw;

  // sequencing
  prsd_state_t                 state_ff;
  prsd_state_t                 nxt_state;
  logic [1:0]                  settle_ff;
  logic [1:0]                  nxt_settle;

  // captured configuration
  logic [PLAT_CODE_W-1:0]      plat_code_ff;
  logic [PLAT_CODE_W-1:0]      nxt_plat_code;
  logic [CORE_CODE_W-1:0]      core_code_ff;
  logic [CORE_CODE_W-1:0]      nxt_core_code;
  logic [PLAT_MULT_W-1:0]      plat_mult_ff;
  logic [PLAT_MULT_W-1:0]      nxt_plat_mult;
  logic [CORE_HALF_W-1:0]      core_half_ff;
  logic [CORE_HALF_W-1:0]      nxt_core_half;
  logic                        invalid_ff;
  logic                        nxt_invalid;
  logic                        run_ff;
  logic                        nxt_run;

  // memory bus divider
  logic                        pclk_prev_ff;
  logic                        nxt_pclk_prev;
  logic                        mem_clk_ff;
  logic                        nxt_mem_clk;

  // decode of the synchronised straps
  logic [PLAT_MULT_W-1:0]      dec_plat;
  logic [CORE_HALF_W-1:0]      dec_core;
  logic                        plat_bad;
  logic                        core_bad;

  assign pin_raw = {platform_bus_clock, core_ratio_strap_msb, core_ratio_strap_mid,
                    core_ratio_strap_lsb, platform_ratio_strap};

  // one synchroniser per pin; only stage two reads stage one, so no
  // half-settled level can reach the decoders or the edge detector
  for (genvar gi = 0; gi < 8; gi++) begin : g_sync
    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb begin
      nxt_stage1 = pin_raw[gi];
      nxt_stage2 = stage1_ff;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        stage1_ff <= 1'b0;
        stage2_ff <= 1'b0;
      end else begin
        stage1_ff <= nxt_stage1;
        stage2_ff <= nxt_stage2;
      end
    end

    assign sync2_ff[gi] = stage2_ff;
  end

  // platform decode; reserved codes leave the multiplier at zero
  always_comb begin
    dec_plat = PLAT_MULT_RST;
    plat_bad = 1'b0;
    case (sync2_ff[3:0])
      4'h0: dec_plat = PMUL_16;
      4'h2: dec_plat = PMUL_2;
      4'h3: dec_plat = PMUL_3;
      4'h4: dec_plat = PMUL_4;
      4'h5: dec_plat = PMUL_5;
      4'h6: dec_plat = PMUL_6;
      4'h8: dec_plat = PMUL_8;
      4'h9: dec_plat = PMUL_9;
      4'ha: dec_plat = PMUL_10;
      4'hc: dec_plat = PMUL_12;
      4'hd: dec_plat = PMUL_20;
      default: plat_bad = 1'b1;
    endcase
  end

  // core ratio in half steps; msb/mid/lsb sit in sync bits 6..4
  always_comb begin
    dec_core = CORE_HALF_RST;
    core_bad = 1'b0;
    case (sync2_ff[6:4])
      3'h0: dec_core = CHALF_8;
      3'h1: dec_core = CHALF_9;
      3'h3: dec_core = CHALF_3;
      3'h4: dec_core = CHALF_4;
      3'h5: dec_core = CHALF_5;
      3'h6: dec_core = CHALF_6;
      3'h7: dec_core = CHALF_7;
      default: core_bad = 1'b1;
    endcase
  end

  // sample once; later strap changes are ignored until the next reset
  always_comb begin
    nxt_state     = state_ff;
    nxt_settle    = settle_ff;
    nxt_plat_code = plat_code_ff;
    nxt_core_code = core_code_ff;
    nxt_plat_mult = plat_mult_ff;
    nxt_core_half = core_half_ff;
    nxt_invalid   = invalid_ff;
    nxt_run       = run_ff;
    case (state_ff)
      PRSD_SETTLE: begin
        // counts 0..2: sample state entered at the third edge, capture on the fourth
        nxt_settle = settle_ff + 2'h1;
        if (settle_ff == SETTLE_CYCLES - 2'h1) begin
          nxt_state = PRSD_SAMPLE;
        end
      end
      PRSD_SAMPLE: begin
        nxt_plat_code = sync2_ff[3:0];
        nxt_core_code = sync2_ff[6:4];
        nxt_plat_mult = dec_plat;
        nxt_core_half = dec_core;
        nxt_invalid   = plat_bad | core_bad;
        nxt_run       = ~(plat_bad | core_bad);
        nxt_state     = PRSD_RUN;
      end
      PRSD_RUN: begin
        nxt_state = PRSD_RUN;
      end
      default: begin
        nxt_state = PRSD_SETTLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff     <= PRSD_SETTLE;
      settle_ff    <= 2'h0;
      plat_code_ff <= PLAT_CODE_RST;
      core_code_ff <= CORE_CODE_RST;
      plat_mult_ff <= PLAT_MULT_RST;
      core_half_ff <= CORE_HALF_RST;
      invalid_ff   <= 1'b0;
      run_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      settle_ff    <= nxt_settle;
      plat_code_ff <= nxt_plat_code;
      core_code_ff <= nxt_core_code;
      plat_mult_ff <= nxt_plat_mult;
      core_half_ff <= nxt_core_half;
      invalid_ff   <= nxt_invalid;
      run_ff       <= nxt_run;
    end
  end

  // memory bus clock toggles on each rising platform edge while run_ff is set (valid config): half rate
  // limitation: platform clock must be under half of ref_clk to be seen
  always_comb begin
    nxt_pclk_prev = sync2_ff[7];
    nxt_mem_clk   = mem_clk_ff;
    if (run_ff && sync2_ff[7] && !pclk_prev_ff) begin
      nxt_mem_clk = ~mem_clk_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pclk_prev_ff <= 1'b0;
      mem_clk_ff   <= 1'b0;
    end else begin
      pclk_prev_ff <= nxt_pclk_prev;
      mem_clk_ff   <= nxt_mem_clk;
    end
  end

  assign plat_code         = plat_code_ff;
  assign core_code         = core_code_ff;
  assign plat_mult         = plat_mult_ff;
  assign core_ratio_halves = core_half_ff;
  assign cfg_valid         = run_ff;
  assign cfg_invalid       = invalid_ff;
  assign plat_pll_enable   = run_ff;
  assign core_pll_enable   = run_ff;
  assign mem_bus_clock     = mem_clk_ff;
endmodule // prsd_pll_ratio_strap_decoder

// file: prsd_board.sv
`timescale 1ns/1ps
module prsd_board (
  // bench commands
  input  wire logic       clk,
  input  wire logic [3:0] p_code,
  input  wire logic [2:0] c_code,
  input  wire logic       run,
  // strap pins and clock feedback
  output logic [3:0]      p_strap,
  output logic [2:0]      c_strap,
  output logic            pbc
);
  logic [1:0] cnt = 2'h0;
  // straps always driven; reserved codes appear only when a test asks
  assign p_strap = p_code;
  assign c_strap = c_code;
  initial pbc = 1'b0;
  // feedback kept at a sixth of ref rate, well inside the sync limit
  always @(negedge clk) begin
    cnt <= (!run || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    pbc <= run & (pbc ^ (cnt == 2'h2));
  end
endmodule // prsd_board

// file: prsd_pll_ratio_strap_decoder_chk.sv
`timescale 1ns/1ps
module prsd_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       platform_bus_clock,
  input wire logic [3:0] plat_code,
  input wire logic [2:0] core_code,
  input wire logic [4:0] plat_mult,
  input wire logic [3:0] core_ratio_halves,
  input wire logic       cfg_valid,
  input wire logic       cfg_invalid,
  input wire logic       plat_pll_enable,
  input wire logic       core_pll_enable,
  input wire logic       mem_bus_clock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic prsv;
  logic cap;
  assign prsv = plat_code inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf};
  assign cap = cfg_valid | cfg_invalid;
  chk_pll_enables: assert property (plat_pll_enable == cfg_valid && core_pll_enable == cfg_valid)
    else $error("pll enable differs from cfg_valid");
  chk_flags_excl: assert property (!(cfg_valid && cfg_invalid))
    else $error("valid and invalid both set");
  chk_plat_rsv: assert property (cap && prsv |-> cfg_invalid && plat_mult == 5'h00)
    else $error("reserved platform code not flagged");
  chk_core_rsv: assert property (cap && core_code == 3'h2 |-> cfg_invalid && core_ratio_halves == 4'h0)
    else $error("reserved core code not flagged");
  chk_legal_valid: assert property (cap && !prsv && core_code != 3'h2 |-> cfg_valid && plat_mult != 5'h00)
    else $error("legal codes not accepted");
  chk_cfg_hold: assert property (cap |=> $stable(plat_code) && $stable(core_code) && $stable(cfg_valid))
    else $error("captured configuration changed");
  chk_mem_idle: assert property (!cfg_valid |-> !mem_bus_clock)
    else $error("memory clock runs without valid config");
  chk_mem_follow: assert property (cfg_valid && $rose(platform_bus_clock) |-> ##[1:4] $changed(mem_bus_clock))
    else $error("memory clock missed a platform edge");
endmodule // prsd_chk
bind prsd_pll_ratio_strap_decoder prsd_chk i_prsd_chk (.ref_clk(ref_clk), .rst(rst),
  .platform_bus_clock(platform_bus_clock), .plat_code(plat_code), .core_code(core_code), .plat_mult(plat_mult),
  .core_ratio_halves(core_ratio_halves), .cfg_valid(cfg_valid), .cfg_invalid(cfg_invalid),
  .plat_pll_enable(plat_pll_enable), .core_pll_enable(core_pll_enable), .mem_bus_clock(mem_bus_clock));

// file: pll_ratio_strap_decoder_bench.sv
`timescale 1ns/1ps
module pll_ratio_strap_decoder_bench;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] pc = 4'h0;
  logic [2:0] cc = 3'h0;
  logic       run = 1'b0;
  logic [3:0] ps, plat_code, core_ratio_halves;
  logic [2:0] cs, core_code;
  logic [4:0] plat_mult;
  logic       pbc, cfg_valid, cfg_invalid, pe, ce, mbc;
  int         n_errors = 0;
  int         samples_checked = 0;
  logic [4:0] pm [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
                          5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h14, 5'h00, 5'h00};
  logic [3:0] ch [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  always #5 ref_clk = ~ref_clk;
  prsd_board i_prsd_board (.clk(ref_clk), .p_code(pc), .c_code(cc), .run(run), .p_strap(ps), .c_strap(cs), .pbc(pbc));
  prsd_pll_ratio_strap_decoder i_prsd_pll_ratio_strap_decoder (.ref_clk(ref_clk), .rst(rst),
    .platform_ratio_strap(ps), .core_ratio_strap_msb(cs[2]), .core_ratio_strap_mid(cs[1]),
    .core_ratio_strap_lsb(cs[0]), .platform_bus_clock(pbc), .plat_code(plat_code), .core_code(core_code),
    .plat_mult(plat_mult), .core_ratio_halves(core_ratio_halves), .cfg_valid(cfg_valid),
    .cfg_invalid(cfg_invalid), .plat_pll_enable(pe), .core_pll_enable(ce), .mem_bus_clock(mbc));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset with straps set, then walk the settle window to the capture edge
  task capture(input logic [3:0] p, input logic [2:0] c);
    @(negedge ref_clk);
    rst = 1'b1;
    pc = p;
    cc = c;
    repeat (4) @(negedge ref_clk);
    chk("reset_out", 8'h00, {cfg_valid, cfg_invalid, pe, ce, mbc});
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("early_cfg", 8'h00, {cfg_valid, cfg_invalid, pe, ce});
    @(negedge ref_clk);
  endtask
  task check_cfg(input logic [3:0] p, input logic [2:0] c);
    logic ok;
    ok = pm[p] != 5'h00 && ch[c] != 4'h0;
    chk("plat_code", {4'h0, p}, plat_code);
    chk("core_code", {5'h0, c}, core_code);
    chk("plat_mult", {3'h0, pm[p]}, plat_mult);
    chk("core_halves", {4'h0, ch[c]}, core_ratio_halves);
    chk("cfg_flags", {4'h0, ok, !ok, ok, ok}, {cfg_valid, cfg_invalid, pe, ce});
  endtask
  task t_plat_codes;
    for (int i = 0; i < 16; i++) begin
      capture(i[3:0], 3'h0);
      check_cfg(i[3:0], 3'h0);
    end
    $display("t_plat_codes done");
  endtask
  task t_core_codes;
    for (int i = 0; i < 8; i++) begin
      capture(4'hd, i[2:0]);
      check_cfg(4'hd, i[2:0]);
    end
    $display("t_core_codes done");
  endtask
  task t_late_change;
    capture(4'h9, 3'h5);
    pc = 4'h1;
    cc = 3'h2;
    repeat (8) @(negedge ref_clk);
    check_cfg(4'h9, 3'h5);
    $display("t_late_change done");
  endtask
  // divide-by-two shows as one memory toggle per platform rise
  task t_mem_clock;
    int r, t;
    logic lp, lm, hi;
    capture(4'h8, 3'h3);
    {r, t, lp, lm, hi} = '0;
    // feedback starts after capture, so every counted rise is one the divider may act on
    run = 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      r += int'(pbc && !lp);
      t += int'(mbc !== lm);
      lp = pbc;
      lm = mbc;
    end
    chk("mem_toggles", 8'h01, {7'h0, t <= r && t + 1 >= r && r > 8});
    capture(4'hf, 3'h0);
    for (int i = 0; i < 30; i++) begin
      @(negedge ref_clk);
      hi = hi | mbc;
    end
    chk("mem_idle", 8'h00, {7'h0, hi});
    run = 1'b0;
    $display("t_mem_clock done");
  endtask
  initial begin
    t_plat_codes;
    t_core_codes;
    t_late_change;
    t_mem_clock;
    test_done;
  end
endmodule // pll_ratio_strap_decoder_bench
